//--- mmbr_backup_restore.sv
// Purpose: Pushbutton and software driven project backup and restore.
// Assumes: Transfer engine reports completion with a one-cycle pulse.
// Notes:   Mode is chosen once, at the first cycle after reset release.
//
// Local design decisions: strobed register access and the register offsets.

`timescale 1ns/1ps
`default_nettype none

// Function
// - Backup and restore start only while the module sits in slot 1.
// - Power-up with the module present enters a halted fault state that accepts commands.
// - Restore is refused when the stored password does not match.
// - Firmware goes with the project only on a software request.
// - In fault state power is green, run off, fault red, lock green, comms off.
// - With a verified configuration the I/O indicators cycle the verification digits.
// - Unverified shows input 0 and outputs 1 to 4 lit and refuses backup.
// - The backup button starts a backup and the module LED flashes until done.
// - Backup while unverified keeps the LED dark, then steady after 15 seconds.
// - Both buttons held about 5 seconds start a restore with the LED flashing.
// - A started restore runs to completion whatever the buttons do.
// - After restore the flashing stops and the new digits are cycled.
// - Restore is allowed when unverified if the module image is verified.
// - Power-up without the module resumes normal application execution.
module mmbr_backup_restore
  import mmbr_pkg::*;
#(
  parameter int unsigned P_DEB_CYC    = 32'(DEB_CYC),
  parameter int unsigned P_FLASH_CYC  = 32'(FLASH_CYC),
  parameter int unsigned P_DIGIT_CYC  = 32'(DIGIT_CYC),
  parameter int unsigned P_HOLD_CYC   = 32'(HOLD_CYC),
  parameter int unsigned P_REJECT_CYC = 32'(REJECT_CYC)
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_resetn,
  input  wire logic [7:0]                  i_addr,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [31:0]                 o_rdata,
  input  wire logic                        i_module_present,
  input  wire logic                        i_config_verified,
  input  wire logic                        i_image_verified,
  input  wire logic                        i_password_match,
  input  wire logic [DIGITS*DIGIT_W-1:0]   i_verif_number,
  input  wire logic                        i_backup_button,
  input  wire logic                        i_memory_identify_button,
  input  wire logic                        i_xfer_done,
  input  wire logic [IN_LEDS-1:0]          i_app_in_leds,
  input  wire logic [OUT_LEDS-1:0]         i_app_out_leds,
  input  wire logic                        i_app_comms,
  input  wire logic                        i_app_lock,
  output logic                             o_backup_start,
  output logic                             o_restore_start,
  output logic                             o_with_firmware,
  output logic                             o_app_run,
  output logic                             o_power_indicator,
  output logic                             o_run_indicator,
  output logic                             o_fault_indicator,
  output logic                             o_lock_indicator,
  output logic                             o_comms_indicator,
  output logic      [IN_LEDS-1:0]          o_in_leds,
  output logic      [OUT_LEDS-1:0]         o_out_leds,
  output logic                             o_module_led,
  output logic                             o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Buttons and display helpers.

  logic                 bkp_btn;
  logic                 mid_btn;
  logic                 bkp_btn_q;
  logic [IN_LEDS-1:0]   cyc_in;
  logic [OUT_LEDS-1:0]  cyc_out;

  mmbr_debounce #(.P_CYC(P_DEB_CYC)) u_deb_bkp (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_raw      (i_backup_button),
    .o_level    (bkp_btn)
  );

  mmbr_debounce #(.P_CYC(P_DEB_CYC)) u_deb_mid (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_raw      (i_memory_identify_button),
    .o_level    (mid_btn)
  );

  mmbr_digit_cycle #(.P_CYC(P_DIGIT_CYC)) u_cycle (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_number   (i_verif_number),
    .o_in_pat   (cyc_in),
    .o_out_pat  (cyc_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State, counters and registers.

  mmbr_state_e       state;
  mmbr_state_e       next_state;
  logic [31:0]       hold_cnt;
  logic [31:0]       rej_cnt;
  logic [31:0]       flash_cnt;
  logic              flash_ph;
  logic              restored;
  logic [EV_W-1:0]   irq_stat;
  logic [EV_W-1:0]   irq_mask;

  wire in_fault      = state != S_BOOT && state != S_NORMAL;
  wire disp_verified = i_config_verified | restored;
  wire both_held     = bkp_btn & mid_btn;
  wire bkp_press     = bkp_btn & ~bkp_btn_q & ~mid_btn;
  wire hold_done     = both_held && hold_cnt == P_HOLD_CYC - 1;
  wire rej_done      = rej_cnt == P_REJECT_CYC - 1;
  wire flash_step    = flash_cnt == P_FLASH_CYC - 1;

  wire wr_ctrl  = i_wr && i_addr == REG_CTRL;
  wire wr_istat = i_wr && i_addr == REG_IRQ_STAT;
  wire wr_imask = i_wr && i_addr == REG_IRQ_MASK;
  wire fw_go    = wr_ctrl && i_wdata[CTRL_FW_BACKUP];

  wire cmd_st   = state == S_IDLE || state == S_REJECTED;
  wire idle_ok  = cmd_st && i_module_present;
  wire go_fw    = idle_ok && fw_go && i_config_verified;
  wire go_bkp   = idle_ok && bkp_press && i_config_verified;
  wire go_rej   = idle_ok && (bkp_press || fw_go) && !i_config_verified;
  wire can_rst  = i_password_match && i_image_verified;
  wire go_rst   = idle_ok && hold_done && can_rst;
  wire rst_ref  = idle_ok && hold_done && !can_rst;
  wire start_rst = go_rst && !(go_bkp || go_fw || go_rej);

  wire [EV_W-1:0] events = {rst_ref,
                            go_rej,
                            state == S_RESTORE && i_xfer_done,
                            state == S_BACKUP && i_xfer_done};

  always_comb begin
    next_state = state;
    unique case (state)
      S_BOOT:     next_state = i_module_present ? S_IDLE : S_NORMAL;
      S_NORMAL:   next_state = S_NORMAL;
      S_IDLE: begin
        if (go_bkp || go_fw) next_state = S_BACKUP;
        else if (go_rej) next_state = S_REJ_WAIT;
        else if (go_rst) next_state = S_RESTORE;
      end
      S_BACKUP:   if (i_xfer_done) next_state = S_IDLE;
      S_REJ_WAIT: if (rej_done) next_state = S_REJECTED;
      S_REJECTED: begin
        if (go_rej) next_state = S_REJ_WAIT;
        else if (go_rst) next_state = S_RESTORE;
      end
      S_RESTORE:  if (i_xfer_done) next_state = S_IDLE;
      default:    next_state = S_BOOT;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator and output next values.

  logic [IN_LEDS-1:0]  next_in;
  logic [OUT_LEDS-1:0] next_out;
  logic [31:0]         next_rdata;

  always_comb begin
    if (!in_fault) begin
      next_in  = i_app_in_leds;
      next_out = i_app_out_leds;
    end else if (disp_verified) begin
      next_in  = cyc_in;
      next_out = cyc_out;
    end else begin
      next_in  = IN_LEDS'(1);
      next_out = OUT_LEDS'(5'h1e);
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    if (i_rd) begin
      unique case (i_addr)
        REG_STATUS:   next_rdata = {26'h0, restored, disp_verified,
                                    in_fault, state};
        REG_IRQ_STAT: next_rdata = 32'(irq_stat);
        REG_IRQ_MASK: next_rdata = 32'(irq_mask);
        default:      next_rdata = 32'h0;
      endcase
    end
  end

  wire next_led = (state == S_BACKUP || state == S_RESTORE) ? flash_ph
                : state == S_REJECTED;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and counters.

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      state     <= S_BOOT;
      bkp_btn_q <= 1'b0;
      hold_cnt  <= 32'h0;
      rej_cnt   <= 32'h0;
      flash_cnt <= 32'h0;
      flash_ph  <= 1'b0;
      restored  <= 1'b0;
    end else begin
      state     <= next_state;
      bkp_btn_q <= bkp_btn;
      hold_cnt  <= (both_held && cmd_st && !hold_done)
                   ? hold_cnt + 32'h1 : 32'h0;
      rej_cnt   <= (state == S_REJ_WAIT) ? rej_cnt + 32'h1 : 32'h0;
      flash_cnt <= (next_state == state && !flash_step)
                   ? flash_cnt + 32'h1 : 32'h0;
      flash_ph  <= (next_state != state) ? 1'b1 : flash_ph ^ flash_step;
      if (state == S_RESTORE && i_xfer_done) restored <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      irq_stat <= '0;
      irq_mask <= IRQ_MASK_RST;
      o_rdata  <= 32'h0;
      o_irq    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_istat ? i_wdata[EV_W-1:0] : '0))
                  | events;
      if (wr_imask) irq_mask <= i_wdata[EV_W-1:0];
      o_rdata  <= next_rdata;
      o_irq    <= |(irq_stat & irq_mask);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_backup_start    <= 1'b0;
      o_restore_start   <= 1'b0;
      o_with_firmware   <= 1'b0;
      o_app_run         <= 1'b0;
      o_power_indicator <= 1'b0;
      o_run_indicator   <= 1'b0;
      o_fault_indicator <= 1'b0;
      o_lock_indicator  <= 1'b0;
      o_comms_indicator <= 1'b0;
      o_in_leds         <= '0;
      o_out_leds        <= '0;
      o_module_led      <= 1'b0;
    end else begin
      o_backup_start    <= go_bkp || go_fw;
      o_restore_start   <= start_rst;
      o_with_firmware   <= (go_bkp || go_fw) ? go_fw : o_with_firmware;
      o_app_run         <= state == S_NORMAL;
      o_power_indicator <= state != S_BOOT;
      o_run_indicator   <= state == S_NORMAL;
      o_fault_indicator <= in_fault;
      o_lock_indicator  <= in_fault | (state == S_NORMAL && i_app_lock);
      o_comms_indicator <= state == S_NORMAL && i_app_comms;
      o_in_leds         <= next_in;
      o_out_leds        <= next_out;
      o_module_led      <= next_led;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  slot_gate_a: assert property (
    o_backup_start || o_restore_start |-> $past(i_module_present))
    else $error("Transfer started without module in slot 1.");

  boot_fault_a: assert property (
    state == S_BOOT && i_module_present |=> state == S_IDLE ##1 !o_app_run)
    else $error("Module present at power-up did not halt logic.");

  password_a: assert property (
    $rose(o_restore_start) |-> $past(i_password_match))
    else $error("Restore started with password mismatch.");

  firmware_a: assert property (
    o_backup_start && o_with_firmware |-> $past(fw_go))
    else $error("Firmware backup without software request.");

  fault_leds_a: assert property (
    in_fault [*2] |-> o_power_indicator && !o_run_indicator &&
      o_fault_indicator && o_lock_indicator && !o_comms_indicator)
    else $error("Fault state indicators wrong.");

  unverified_a: assert property (
    (in_fault && !disp_verified) [*2] |->
      o_in_leds == IN_LEDS'(1) && o_out_leds == OUT_LEDS'(5'h1e))
    else $error("Unverified pattern wrong.");

  no_backup_a: assert property (
    state == S_IDLE && !i_config_verified |=> !o_backup_start)
    else $error("Backup started while unverified.");

  reject_dark_a: assert property (
    state == S_REJ_WAIT [*2] |-> !o_module_led)
    else $error("Module LED lit during reject wait.");

  reject_on_a: assert property (
    state == S_REJ_WAIT && rej_done |=> state == S_REJECTED ##1 o_module_led)
    else $error("Reject not shown steady after wait.");

  restore_run_a: assert property (
    state == S_RESTORE && !i_xfer_done |=> state == S_RESTORE)
    else $error("Restore aborted before completion.");

  normal_run_a: assert property (
    state == S_BOOT && !i_module_present |=> ##1 o_app_run && !o_fault_indicator)
    else $error("Normal execution not resumed.");

  irq_level_a: assert property (
    o_irq |-> $past(|(irq_stat & irq_mask)))
    else $error("Interrupt without unmasked status.");

  restore_gate_a: assert property (
    o_restore_start |-> $past(i_image_verified && i_password_match))
    else $error("Restore started from an unusable image.");

  backup_flash_a: assert property (
    $rose(o_backup_start) |=> o_module_led)
    else $error("Module LED not lit at backup start.");

  restore_dark_a: assert property (
    state == S_RESTORE && i_xfer_done |=> ##1 !o_module_led)
    else $error("Module LED still lit after restore.");

  single_start_a: assert property (
    !(o_backup_start && o_restore_start))
    else $error("Backup and restore started together.");

  normal_quiet_a: assert property (
    state == S_NORMAL |=> !o_backup_start && !o_restore_start)
    else $error("Transfer started in normal execution.");

  backup_c:  cover property (state == S_BACKUP && i_xfer_done);
  restore_c: cover property (state == S_RESTORE && i_xfer_done);
  reject_c:  cover property (state == S_REJ_WAIT ##1 state == S_REJECTED);
  refuse_c:  cover property (rst_ref);

endmodule

`default_nettype wire

//--- mmbr_debounce.sv
// Purpose: Synchronise and debounce one pushbutton.
// Assumes: Button is active high.
// Notes:   Level changes only after P_CYC stable cycles.

`timescale 1ns/1ps
`default_nettype none

module mmbr_debounce
  import mmbr_pkg::*;
#(
  parameter int unsigned P_CYC = 32'(DEB_CYC)
) (
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  input  wire logic i_raw,
  output var  logic o_level
);

  logic        sync1;
  logic        sync2;
  logic [31:0] cnt;
  wire         differs = sync2 != o_level;
  wire         settled = cnt == P_CYC - 1;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      sync1   <= 1'b0;
      sync2   <= 1'b0;
      cnt     <= 32'h0;
      o_level <= 1'b0;
    end else begin
      sync1 <= i_raw;
      sync2 <= sync1;
      cnt   <= (differs && !settled) ? cnt + 32'h1 : 32'h0;
      if (differs && settled) o_level <= sync2;
    end
  end

endmodule

`default_nettype wire

//--- mmbr_digit_cycle.sv
// Purpose: Step through the verification digits for the indicators.
// Assumes: Digits are packed lowest digit first.
// Notes:   Shows digit value one-hot on inputs, position on outputs.

`timescale 1ns/1ps
`default_nettype none

module mmbr_digit_cycle
  import mmbr_pkg::*;
#(
  parameter int unsigned P_CYC  = 32'(DIGIT_CYC),
  parameter int unsigned P_NDIG = DIGITS,
  parameter int unsigned P_IN   = IN_LEDS,
  parameter int unsigned P_OUT  = OUT_LEDS
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_resetn,
  input  wire logic [P_NDIG*DIGIT_W-1:0]  i_number,
  output logic      [P_IN-1:0]            o_in_pat,
  output logic      [P_OUT-1:0]           o_out_pat
);

  logic [31:0] tick;
  logic [7:0]  idx;
  wire         step = tick == P_CYC - 1;
  wire  [DIGIT_W-1:0] digit = i_number[idx*DIGIT_W +: DIGIT_W];

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      tick <= 32'h0;
      idx  <= 8'h0;
    end else begin
      tick <= step ? 32'h0 : tick + 32'h1;
      if (step) idx <= (idx == 8'(P_NDIG - 1)) ? 8'h0 : idx + 8'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < P_IN; g++) begin : g_in
      assign o_in_pat[g] = 32'(digit) == g;
    end
    for (g = 0; g < P_OUT; g++) begin : g_out
      assign o_out_pat[g] = 32'(idx) == g;
    end
  endgenerate

endmodule

`default_nettype wire

//--- mmbr_module_model.sv
// Purpose: Behavioural transfer engine of the plug-in memory module.
// Assumes: Start pulses arrive one at a time.
// Notes:   Done is a one-cycle pulse after a short or a long copy.

`timescale 1ns/1ps
`default_nettype none

module mmbr_module_model (
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  input  wire logic i_start,
  input  wire logic i_slow,
  output logic      o_done
);
  int cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Counts the copy time, then pulses done once.
  always_ff @(posedge i_core_clk) begin
    o_done <= 1'b0;
    if (!i_resetn) begin
      cnt <= 0;
    end else if (i_start) begin
      cnt <= i_slow ? 40 : 6;
    end else if (cnt == 1) begin
      cnt    <= 0;
      o_done <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

`default_nettype wire

//--- mmbr_pkg.sv
// Purpose: Shared constants for the memory module backup/restore block.
// Assumes: Core clock of 250 MHz.
// Notes:   Times are in milliseconds; cycle counts derive from them.

`default_nettype none

package mmbr_pkg;

  localparam longint unsigned CLK_KHZ     = 250000;
  localparam longint unsigned T_DEB_MS    = 10;
  localparam longint unsigned T_FLASH_MS  = 250;
  localparam longint unsigned T_DIGIT_MS  = 1000;
  localparam longint unsigned T_HOLD_MS   = 5000;
  localparam longint unsigned T_REJECT_MS = 15000;
  localparam longint unsigned DEB_CYC     = T_DEB_MS * CLK_KHZ;
  localparam longint unsigned FLASH_CYC   = T_FLASH_MS * CLK_KHZ;
  localparam longint unsigned DIGIT_CYC   = T_DIGIT_MS * CLK_KHZ;
  localparam longint unsigned HOLD_CYC    = T_HOLD_MS * CLK_KHZ;
  localparam longint unsigned REJECT_CYC  = T_REJECT_MS * CLK_KHZ;

  localparam int unsigned DIGIT_W   = 4;
  localparam int unsigned DIGITS    = 4;
  localparam int unsigned IN_LEDS   = 12;
  localparam int unsigned OUT_LEDS  = 10;

  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;

  localparam int unsigned CTRL_FW_BACKUP = 0;
  localparam int unsigned EV_BACKUP_DONE = 0;
  localparam int unsigned EV_RESTORE_DONE = 1;
  localparam int unsigned EV_BACKUP_REJ  = 2;
  localparam int unsigned EV_RESTORE_REJ = 3;
  localparam int unsigned EV_W           = 4;
  localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;

  typedef enum logic [2:0] {
    S_BOOT     = 3'b000,
    S_NORMAL   = 3'b001,
    S_IDLE     = 3'b010,
    S_BACKUP   = 3'b011,
    S_REJ_WAIT = 3'b100,
    S_REJECTED = 3'b101,
    S_RESTORE  = 3'b110
  } mmbr_state_e;

endpackage

`default_nettype wire

//--- testbench.sv
// Purpose: Self-checking bench for the backup and restore block.
// Assumes: Shortened timing parameters.
// Notes:   Boot cases run from a table; transfers are hand-written.

`timescale 1ns/1ps
`default_nettype none

module testbench;
  import mmbr_pkg::*;
  localparam int unsigned HOLD = 20;
  localparam int unsigned REJ  = 30;

  logic        i_core_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic        i_module_present = 1'b1;
  logic        i_config_verified = 1'b1;
  logic        i_image_verified = 1'b1;
  logic        i_password_match = 1'b1;
  logic [15:0] i_verif_number = 16'h3a52;
  logic        i_backup_button = 1'b0;
  logic        i_memory_identify_button = 1'b0;
  logic        i_xfer_done;
  logic        i_slow = 1'b1;
  logic [11:0] i_app_in_leds = 12'h0a5;
  logic [9:0]  i_app_out_leds = 10'h00c;
  logic        i_app_comms = 1'b1;
  logic        i_app_lock = 1'b1;
  logic        o_backup_start, o_restore_start, o_with_firmware, o_app_run;
  logic        o_power_indicator, o_run_indicator, o_fault_indicator;
  logic        o_lock_indicator, o_comms_indicator, o_module_led, o_irq;
  logic [11:0] o_in_leds;
  logic [9:0]  o_out_leds;
  int          failures = 0;
  int          num_checks = 0;
  int          n;
  logic [31:0] d;
  logic [1:0]  row_in [3] = '{2'h3, 2'h2, 2'h0};
  logic [5:0]  row_out [3] = '{6'h2c, 6'h2c, 6'h37};
  logic [2:0]  row_st [3] = '{3'h2, 3'h2, 3'h1};
  wire  [4:0]  ev = {o_irq, i_xfer_done, o_module_led, o_restore_start,
                     o_backup_start};
  wire  [5:0]  ind = {o_power_indicator, o_run_indicator, o_fault_indicator,
                      o_lock_indicator, o_comms_indicator, o_app_run};
  wire         xstart = o_backup_start | o_restore_start;

  always #2 i_core_clk = ~i_core_clk;

  mmbr_backup_restore #(
    .P_DEB_CYC(4), .P_FLASH_CYC(4), .P_DIGIT_CYC(8),
    .P_HOLD_CYC(HOLD), .P_REJECT_CYC(REJ)
  ) DUT (
    .i_core_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_module_present, .i_config_verified, .i_image_verified,
    .i_password_match, .i_verif_number, .i_backup_button,
    .i_memory_identify_button, .i_xfer_done, .i_app_in_leds,
    .i_app_out_leds, .i_app_comms, .i_app_lock, .o_backup_start,
    .o_restore_start, .o_with_firmware, .o_app_run, .o_power_indicator,
    .o_run_indicator, .o_fault_indicator, .o_lock_indicator,
    .o_comms_indicator, .o_in_leds, .o_out_leds, .o_module_led, .o_irq
  );

  mmbr_module_model partner (
    .i_core_clk, .i_resetn, .i_start(xstart), .i_slow, .o_done(i_xfer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic complete_run();
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task automatic btn(input logic b, input logic m);
    @(posedge i_core_clk);
    i_backup_button          <= b;
    i_memory_identify_button <= m;
    #1;
  endtask

  task automatic boot(input logic p, input logic v, input logic pw,
                      input logic s);
    @(posedge i_core_clk);
    i_resetn          <= 1'b0;
    i_module_present  <= p;
    i_config_verified <= v;
    i_password_match  <= pw;
    i_slow            <= s;
    i_verif_number    <= 16'h3a52;
    repeat (4) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    cyc(4);
  endtask

  task automatic wait_bit(input int i, input logic v, input int lim,
                          output int k);
    k = 0;
    while (ev[i] !== v && k < lim) begin
      cyc(1);
      k++;
    end
    if (ev[i] !== v) begin
      failures++;
      $display("BAD wait %0d exp %b got %b", i, v, ev[i]);
      complete_run();
    end
  endtask

  task automatic never(input logic [4:0] m, input int k);
    int hit;
    hit = 0;
    repeat (k) begin
      cyc(1);
      if ((ev & m) !== 5'h00) begin
        hit = 1;
      end
    end
    chk("quiet", 0, hit);
  endtask

  task automatic flash_chk();
    int ones;
    ones = 0;
    repeat (30) begin
      cyc(1);
      ones += int'(o_module_led);
    end
    chk("flash", 1, 32'(ones > 0 && ones < 30));
  endtask

  task automatic chk_digits(input logic [15:0] num);
    int hits;
    logic [3:0] seen;
    hits = 0;
    seen = 4'h0;
    repeat (80) begin
      cyc(1);
      for (int k = 0; k < 4; k++) begin
        if (o_out_leds === 10'(1 << k)) begin
          hits++;
          seen[k] = 1'b1;
          chk("in_leds", 32'(1 << num[k*4 +: 4]), 32'(o_in_leds));
        end
      end
    end
    chk("digit_hits", 1, 32'(hits >= 16));
    chk("digit_pos", 32'hf, 32'(seen));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    cyc(1);
    chk("reset_out", 0, 32'(ind));
    for (int r = 0; r < 3; r++) begin
      boot(row_in[r][1], row_in[r][0], 1'b1, 1'b1);
      chk("indicators", 32'(row_out[r]), 32'(ind));
      rd(REG_STATUS, d);
      chk("state", 32'(row_st[r]), 32'(d[2:0]));
    end
    chk("app_in", 32'h0a5, 32'(o_in_leds));
    chk("app_out", 32'h00c, 32'(o_out_leds));
    btn(1'b1, 1'b0);
    never(5'h03, 12);
    btn(1'b0, 1'b0);
    boot(1'b1, 1'b1, 1'b1, 1'b1);
    chk_digits(16'h3a52);
    btn(1'b1, 1'b0);
    btn(1'b0, 1'b0);
    never(5'h01, 15);
    btn(1'b1, 1'b0);
    wait_bit(0, 1'b1, 40, n);
    chk("with_fw", 0, 32'(o_with_firmware));
    btn(1'b0, 1'b0);
    flash_chk();
    wait_bit(3, 1'b1, 40, n);
    cyc(2);
    never(5'h04, 10);
    rd(REG_IRQ_STAT, d);
    chk("irq_stat", 32'h1, d);
    chk("irq_masked", 0, 32'(o_irq));
    wr(REG_IRQ_MASK, 32'h1);
    cyc(2);
    chk("irq_on", 1, 32'(o_irq));
    wr(REG_IRQ_STAT, 32'h1);
    cyc(2);
    chk("irq_off", 0, 32'(o_irq));
    @(posedge i_core_clk) i_slow <= 1'b0;
    wr(REG_CTRL, 32'h1 << CTRL_FW_BACKUP);
    wait_bit(0, 1'b1, 20, n);
    chk("with_fw", 1, 32'(o_with_firmware));
    wait_bit(3, 1'b1, 20, n);
    rd(8'h10, d);
    chk("unmapped", 0, d);
    rd(REG_CTRL, d);
    chk("ctrl_rd", 0, d);
    boot(1'b1, 1'b0, 1'b1, 1'b1);
    chk("in_leds", 32'h001, 32'(o_in_leds));
    chk("out_leds", 32'h01e, 32'(o_out_leds));
    btn(1'b1, 1'b0);
    never(5'h05, 20);
    btn(1'b0, 1'b0);
    wait_bit(2, 1'b1, 40, n);
    chk("reject_wait", 1, 32'(n + 21 >= REJ));
    cyc(5);
    chk("led_steady", 1, 32'(o_module_led));
    rd(REG_IRQ_STAT, d);
    chk("irq_stat", 32'h4, d);
    btn(1'b1, 1'b1);
    wait_bit(1, 1'b1, 60, n);
    btn(1'b0, 1'b0);
    wait_bit(3, 1'b1, 60, n);
    boot(1'b1, 1'b1, 1'b0, 1'b1);
    btn(1'b1, 1'b1);
    never(5'h02, 40);
    btn(1'b0, 1'b0);
    rd(REG_IRQ_STAT, d);
    chk("irq_stat", 32'h8, d);
    boot(1'b1, 1'b0, 1'b1, 1'b1);
    btn(1'b1, 1'b1);
    wait_bit(1, 1'b1, 60, n);
    chk("hold", 1, 32'(n >= HOLD));
    btn(1'b0, 1'b0);
    @(posedge i_core_clk) i_verif_number <= 16'h0917;
    flash_chk();
    rd(REG_STATUS, d);
    chk("state", 32'h6, 32'(d[2:0]));
    chk("flags", 32'h1, 32'(d[5:3]));
    wait_bit(3, 1'b1, 40, n);
    cyc(3);
    chk("led_off", 0, 32'(o_module_led));
    chk_digits(16'h0917);
    rd(REG_STATUS, d);
    chk("flags", 32'h7, 32'(d[5:3]));
    complete_run();
  end
endmodule

`default_nettype wire
